// File: hw/rtcwk_consts.vh
// Purpose: constants for the weekday counter and first timer control register
// Assumes: included by bare name from files under hw/
// Notes:   byte offsets on a 32-bit AXI4-Lite bus, one register per aligned word
//
// Contract
// - The weekday counter steps by one on every daily carry of the hour counter.
// - The weekday sits in bits 2 to 0 of its register and ranges from 0 to 6.
// - The weekday is binary coded, 000 for Sunday up to 110 for Saturday.
// - Bit 7 of the weekday register is a read-only busy flag, 1 while time values update.
// - Weekday bits 6 to 3 and control bits 3 to 0 always read as 0.
// - Control bit 7 at 1 starts time counting and at 0 stops it.
// - Control bit 6 picks the hour range, 0 to 11 when 0 and 0 to 23 when 1.
// - Control bit 5 shows a.m. at 0 and p.m. at 1, meaningful only in 12-hour format.
// - Control bit 4 resets to 0; at 1 it clears all clock state except itself.
// - The hour counter counts in BCD on the hourly carry and yields the daily carry.
`ifndef RTCWK_CONSTS_VH
`define RTCWK_CONSTS_VH

// ==========================================================
// register map
`define RTCWK_ADDR_W          12
`define RTCWK_OFS_WEEKDAY     12'h000
`define RTCWK_OFS_CONTROL     12'h004
`define RTCWK_OFS_HOUR        12'h008

// ==========================================================
// field positions
`define RTCWK_BUSY_BIT        7
`define RTCWK_WK_MSB          2
`define RTCWK_WK_LSB          0
`define RTCWK_RUN_BIT         7
`define RTCWK_MODE24_BIT      6
`define RTCWK_PM_BIT          5
`define RTCWK_SRST_BIT        4
`define RTCWK_HOUR_MSB        5

// ==========================================================
// values
`define RTCWK_WK_SUNDAY       3'h0
`define RTCWK_WK_SATURDAY     3'h6
`define RTCWK_HOUR_TOP_12     6'h11
`define RTCWK_HOUR_TOP_24     6'h23
`define RTCWK_CTRL_RESET      4'h0
`define RTCWK_RESP_OKAY       2'h0
`define RTCWK_RESP_DECERR     2'h3

// ==========================================================
// timing
`define RTCWK_CLK_PERIOD_NS   10
`define RTCWK_BUSY_TIME_US    62500
`define RTCWK_BUSY_CYCLES     ((`RTCWK_BUSY_TIME_US * 1000) / `RTCWK_CLK_PERIOD_NS)

`endif

// File: hw/rtcwk_hour_counter.v
// Purpose: BCD hour counter with 12/24 range and rollover pulse
// Assumes: step is a one-cycle pulse; hour value survives aresetn
// Notes:   clear beats load, load beats step
`timescale 1ns/100ps
`default_nettype none
`include "rtcwk_consts.vh"

module rtcwk_hour_counter (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       clear,
    input  wire       load,
    input  wire [5:0] load_value,
    input  wire       step,
    input  wire       mode24,
    output reg  [5:0] hour,
    output reg        roll
);
    wire [5:0] hour_top;

    assign hour_top = mode24 ? `RTCWK_HOUR_TOP_24 : `RTCWK_HOUR_TOP_12;

    // ==========================================================
    // hour value, deliberately outside aresetn
    always @(posedge aclk) begin
        if (clear) begin
            hour <= 6'h00;
        end else if (load) begin
            hour <= load_value;
        end else if (step) begin
            if (hour == hour_top) begin
                hour <= 6'h00;
            end else if (hour[3:0] == 4'h9) begin
                hour <= {hour[5:4] + 2'h1, 4'h0};
            end else begin
                hour <= {hour[5:4], hour[3:0] + 4'h1};
            end
        end
    end

    // ==========================================================
    // rollover pulse, one cycle, same edge as the new hour
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            roll <= 1'b0;
        end else begin
            roll <= step && !load && (hour == hour_top);
        end
    end
endmodule // rtcwk_hour_counter

`default_nettype wire

// File: hw/rtcwk_top.v
// Purpose: weekday counter, first timer control register, AXI4-Lite slave
// Assumes: sec_tick and hour_tick are one-cycle pulses synchronous to aclk
// Notes:   time values are not cleared by aresetn, only by the soft reset bit
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rtcwk_consts.vh"

module rtcwk_top #(
    parameter integer BUSY_CYCLES = `RTCWK_BUSY_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sec_tick,
    input  wire        hour_tick,
    output reg         counting
);
    // ==========================================================
    // state
    reg  [11:0] wr_addr;
    reg         aw_held;
    reg  [7:0]  wr_byte;
    reg         w_held;
    reg  [2:0]  weekday;
    reg         ctrl_run;
    reg         ctrl_mode24;
    reg         ctrl_pm;
    reg         ctrl_srst;
    reg         update_in_progress;
    reg  [22:0] busy_cnt;
    reg         hour_pending;
    reg  [1:0]  finish;
    reg  [7:0]  rd_byte;
    reg         rd_hit;
    wire        do_write;
    wire        wr_weekday;
    wire        wr_control;
    wire        wr_hour;
    wire        wr_hit;
    wire        step_issue;
    wire [5:0]  hour;
    wire        hour_roll;
    wire        daily_carry;
    wire        ar_take;

    // ==========================================================
    // write channel: address and data taken in either order
    assign do_write   = aw_held && w_held && !s_axi_bvalid;
    assign wr_weekday = do_write && (wr_addr == `RTCWK_OFS_WEEKDAY);
    assign wr_control = do_write && (wr_addr == `RTCWK_OFS_CONTROL);
    assign wr_hour    = do_write && (wr_addr == `RTCWK_OFS_HOUR);
    assign wr_hit     = (wr_addr == `RTCWK_OFS_WEEKDAY) || (wr_addr == `RTCWK_OFS_CONTROL)
                     || (wr_addr == `RTCWK_OFS_HOUR);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RTCWK_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 12'h000;
            wr_byte       <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                // only byte lane 0 carries register bits
                wr_byte      <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
                w_held       <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
                if (!s_axi_wstrb[0]) begin
                    w_held <= 1'b1;
                end
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RTCWK_RESP_OKAY : `RTCWK_RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // lane 0 strobe remembered so a strobe-less write changes nothing
    reg wr_lane0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wr_lane0 <= s_axi_wstrb[0];
        end
    end

    // ==========================================================
    // control register
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_srst   <= 1'b0;
            ctrl_run    <= 1'b0;
            ctrl_mode24 <= 1'b0;
            ctrl_pm     <= 1'b0;
        end else begin
            if (wr_control && wr_lane0) begin
                ctrl_srst <= wr_byte[`RTCWK_SRST_BIT];
            end
            if (wr_control && wr_lane0) begin
                // write wins, so one write can leave soft reset and start counting
                ctrl_run    <= wr_byte[`RTCWK_RUN_BIT];
                ctrl_mode24 <= wr_byte[`RTCWK_MODE24_BIT];
                ctrl_pm     <= wr_byte[`RTCWK_PM_BIT];
            end else if (ctrl_srst) begin
                // soft reset holds everything but its own bit
                ctrl_run    <= 1'b0;
                ctrl_mode24 <= 1'b0;
                ctrl_pm     <= 1'b0;
            end else if (hour_roll && !ctrl_mode24) begin
                ctrl_pm <= ~ctrl_pm;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            counting <= 1'b0;
        end else begin
            counting <= ctrl_run && !ctrl_srst;
        end
    end

    // ==========================================================
    // update window: busy spans the count, the hour step and the day step
    assign step_issue = update_in_progress && (busy_cnt == 23'd1) && hour_pending;

    always @(posedge aclk) begin
        if (!aresetn || ctrl_srst) begin
            update_in_progress <= 1'b0;
            busy_cnt           <= 23'd0;
            hour_pending       <= 1'b0;
            finish             <= 2'b00;
        end else begin
            finish <= {finish[0], update_in_progress && (busy_cnt == 23'd1)};
            if (ctrl_run && sec_tick && !update_in_progress) begin
                update_in_progress <= 1'b1;
                busy_cnt           <= BUSY_CYCLES[22:0];
            end else if (update_in_progress && busy_cnt > 23'd1) begin
                busy_cnt <= busy_cnt - 23'd1;
            end else if (busy_cnt == 23'd1) begin
                busy_cnt <= 23'd0;
            end
            if (finish[1]) begin
                update_in_progress <= 1'b0;
            end
            // a carry landing on the step cycle stays pending
            if (ctrl_run && hour_tick) begin
                hour_pending <= 1'b1;
            end else if (step_issue) begin
                hour_pending <= 1'b0;
            end
        end
    end

    // ==========================================================
    // hour counter and daily carry
    rtcwk_hour_counter u_hour (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .clear      (ctrl_srst),
        .load       (wr_hour && wr_lane0),
        .load_value (wr_byte[5:0]),
        .step       (step_issue && ctrl_run),
        .mode24     (ctrl_mode24),
        .hour       (hour),
        .roll       (hour_roll)
    );

    // in 12-hour form a day ends when 11 p.m. rolls to 0
    assign daily_carry = hour_roll && (ctrl_mode24 || ctrl_pm);

    // ==========================================================
    // weekday counter, kept across aresetn
    always @(posedge aclk) begin
        if (ctrl_srst) begin
            weekday <= `RTCWK_WK_SUNDAY;
        end else if (wr_weekday && wr_lane0) begin
            weekday <= wr_byte[`RTCWK_WK_MSB:`RTCWK_WK_LSB];
        end else if (daily_carry) begin
            if (weekday == `RTCWK_WK_SATURDAY) begin
                weekday <= `RTCWK_WK_SUNDAY;
            end else begin
                weekday <= weekday + 3'h1;
            end
        end
    end

    // ==========================================================
    // read channel
    always @* begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `RTCWK_OFS_WEEKDAY: begin
                rd_byte = {update_in_progress, 4'h0, weekday};
            end
            `RTCWK_OFS_CONTROL: begin
                rd_byte = {ctrl_run, ctrl_mode24, ctrl_pm, ctrl_srst, 4'h0};
            end
            `RTCWK_OFS_HOUR: begin
                rd_byte = {update_in_progress, 1'b0, hour};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign ar_take = s_axi_arvalid && s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RTCWK_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_byte};
                s_axi_rresp   <= rd_hit ? `RTCWK_RESP_OKAY : `RTCWK_RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // rtcwk_top

`default_nettype wire

// File: testbench/rtcwk_top_asserts.sv
// Purpose: port-level checks for rtcwk_top
// Assumes: bound to every rtcwk_top instance
// Notes:   weekday at 0x000, control at 0x004, hour at 0x008
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// checker
module rtcwk_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        counting
);
    logic [11:0] wa;
    logic [11:0] ra;
    logic [7:0]  wd;
    logic        ws;

    // aw and w may be taken on different edges, so each is kept on its own
    always @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            wa <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata[7:0];
            ws <= s_axi_wstrb[0];
        end
        if (s_axi_arvalid && s_axi_arready) begin
            ra <= s_axi_araddr;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ctl_wr(logic run);
        $rose(s_axi_bvalid) && wa == 12'h004 && ws && !wd[4] && wd[7] == run;
    endsequence

    sequence srst_wr;
        $rose(s_axi_bvalid) && wa == 12'h004 && ws && wd[4];
    endsequence

    run_start_a: assert property (ctl_wr(1'h1) |-> ##[0:2] counting)
        else $error("counting did not start after run write");
    run_stop_a: assert property (ctl_wr(1'h0) |-> ##[0:2] !counting)
        else $error("counting did not stop after run clear");
    srst_stop_a: assert property (srst_wr |-> ##[0:2] !counting)
        else $error("counting kept on under soft reset");
    wk_resv_a: assert property (s_axi_rvalid && ra == 12'h000 |-> s_axi_rdata[6:3] == 4'h0)
        else $error("weekday reserved bits not zero");
    ctl_resv_a: assert property (s_axi_rvalid && ra == 12'h004 |-> s_axi_rdata[3:0] == 4'h0)
        else $error("control reserved bits not zero");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    unmapped_a: assert property ($rose(s_axi_bvalid) && wa == 12'h00c |-> s_axi_bresp == 2'h3)
        else $error("unmapped write not refused");
endmodule // rtcwk_asserts

bind rtcwk_top rtcwk_asserts u_rtcwk_asserts (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .counting);

`default_nettype wire

// File: testbench/rtc_weekday_and_control_bench.sv
// Purpose: directed bench for rtcwk_top
// Assumes: busy count shortened to 5 cycles, so the update window lasts 7 cycles
// Notes:   weekday 0x000, control 0x004, hour 0x008, 0x00c unmapped
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module rtc_weekday_and_control_bench;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        sec_tick = 1'h0, hour_tick = 1'h0;
    logic [3:0]  wstrb = 4'h1;
    wire         awready, wready, bvalid, arready, rvalid, counting;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          err_count = 0, checks_done = 0, cyc = 0, i;

    rtcwk_top #(.BUSY_CYCLES(5)) u_rtcwk_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sec_tick(sec_tick), .hour_tick(hour_tick),
        .counting(counting));

    always #5 aclk = ~aclk;

    // ==========================================================
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ap, dp;
        ap = 1'h1;
        dp = 1'h1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (ap || dp) begin
            @(posedge aclk);
            if (ap && awready) begin
                ap = 1'h0;
                awvalid <= 1'h0;
            end
            if (dp && wready) begin
                dp = 1'h0;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        `CHK("bresp", er, bresp)
    endtask

    task automatic rr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        v = rdata;
        r = rresp;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0]  r;
        rr(a, v, r);
        `CHK("rdata", {24'h0, e}, v)
        `CHK("rresp", er, r)
    endtask

    // hourly carry then a second tick; waits out the update window
    task automatic tick(input logic busy);
        logic [31:0] v;
        logic [1:0]  r;
        @(posedge aclk);
        hour_tick <= 1'h1;
        @(posedge aclk);
        hour_tick <= 1'h0;
        sec_tick <= 1'h1;
        @(posedge aclk);
        sec_tick <= 1'h0;
        rr(12'h000, v, r);
        `CHK("busy", busy, v[7])
        for (int k = 0; k < 20 && v[7] !== 1'h0; k++) rr(12'h000, v, r);
        `CHK("busy_end", 1'h0, v[7])
    endtask

    task automatic run_chk(input logic e);
        @(posedge aclk);
        #1;
        `CHK("counting", e, counting)
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(12'h004, 8'h00, 2'h0);
        rd(12'h00c, 8'h00, 2'h3);
        wr(12'h00c, 8'hff, 2'h3);
        wr(12'h004, 8'h6f, 2'h0);
        rd(12'h004, 8'h60, 2'h0);
        // a write without lane 0 strobe must leave the control register alone
        wstrb <= 4'h0;
        wr(12'h004, 8'h9f, 2'h0);
        wstrb <= 4'h1;
        rd(12'h004, 8'h60, 2'h0);
        for (i = 0; i < 7; i++) begin
            wr(12'h000, 8'h78 | i[7:0], 2'h0);
            rd(12'h000, i[7:0], 2'h0);
        end
        $display("test regs done");
    endtask

    task automatic t_wrap();
        wr(12'h008, 8'h23, 2'h0);
        wr(12'h000, 8'h06, 2'h0);
        wr(12'h004, 8'hc0, 2'h0);
        run_chk(1'h1);
        tick(1'h1);
        rd(12'h008, 8'h00, 2'h0);
        rd(12'h000, 8'h00, 2'h0);
        wr(12'h008, 8'h11, 2'h0);
        tick(1'h1);
        rd(12'h008, 8'h12, 2'h0);
        $display("test wrap done");
    endtask

    task automatic t_pm();
        wr(12'h004, 8'h80, 2'h0);
        wr(12'h000, 8'h02, 2'h0);
        wr(12'h008, 8'h11, 2'h0);
        tick(1'h1);
        rd(12'h008, 8'h00, 2'h0);
        rd(12'h004, 8'ha0, 2'h0);
        rd(12'h000, 8'h02, 2'h0);
        wr(12'h008, 8'h11, 2'h0);
        tick(1'h1);
        rd(12'h004, 8'h80, 2'h0);
        rd(12'h000, 8'h03, 2'h0);
        $display("test pm done");
    endtask

    task automatic t_stop();
        wr(12'h004, 8'h40, 2'h0);
        run_chk(1'h0);
        wr(12'h008, 8'h05, 2'h0);
        tick(1'h0);
        rd(12'h008, 8'h05, 2'h0);
        $display("test stop done");
    endtask

    task automatic t_srst();
        wr(12'h000, 8'h04, 2'h0);
        wr(12'h008, 8'h07, 2'h0);
        // running first, so the soft reset has a live count to stop
        wr(12'h004, 8'h80, 2'h0);
        run_chk(1'h1);
        wr(12'h004, 8'hd0, 2'h0);
        rd(12'h004, 8'h10, 2'h0);
        rd(12'h000, 8'h00, 2'h0);
        rd(12'h008, 8'h00, 2'h0);
        run_chk(1'h0);
        wr(12'h004, 8'h00, 2'h0);
        wr(12'h004, 8'h80, 2'h0);
        rd(12'h004, 8'h80, 2'h0);
        run_chk(1'h1);
        $display("test srst done");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run is well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_wrap();
        t_pm();
        t_stop();
        t_srst();
        stop_test();
    end
endmodule // rtc_weekday_and_control_bench

`default_nettype wire
